// ==== rtl/i2cst_pkg.sv ====
// constants and types for the target-side transmit and stretch engine
package i2cst_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK
  } i2cst_state_type;

  localparam logic [4:0] ADDR10_HI = 5'h1e;
  localparam logic [3:0] CNT_BYTE = 4'h8;
  localparam logic [3:0] CNT_TX_LAST = 4'h7;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic CKP_RST = 1'b1;
endpackage

// ==== rtl/i2cst_slave.sv ====
// target-side i2c read engine: address match, transmit, acknowledge, stretching
`timescale 1ns/1ps
module i2cst_slave
  import i2cst_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // serial bus, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // configuration
  input wire logic ten_bit_i,
  input wire logic address_hold_enable_i,
  input wire logic data_hold_enable_i,
  input wire logic stretch_enable_i,
  input wire logic slave_collision_detect_enable_i,
  input wire logic ack_value_select_i,
  // software strobes
  input wire logic buf_wr_i,
  input wire logic [7:0] buf_wdata_i,
  input wire logic buf_rd_i,
  input wire logic own_addr_wr_i,
  input wire logic [7:0] own_addr_wdata_i,
  input wire logic clock_release_set_i,
  input wire logic irq_clr_i,
  input wire logic bcl_clr_i,
  // status
  output logic [7:0] buffer_register_o,
  output logic [7:0] own_address_register_o,
  output logic read_write_flag_o,
  output logic buffer_full_flag_o,
  output logic update_address_flag_o,
  output logic ack_received_flag_o,
  output logic ack_time_flag_o,
  output logic serial_irq_flag_o,
  output logic bus_collision_flag_o,
  output logic clock_release_o
);
  i2cst_state_type state_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sr_ff;
  logic [7:0] buf_ff;
  logic [7:0] own_ff;
  logic is_addr_ff, lo_ff, hi_ok_ff, held_ff, nack_ff;
  logic rw_ff, bf_ff, ua_ff, ack_received_flag_ff, ack_time_flag_ff, irq_ff, bcl_ff, ckp_ff;
  logic scl_oe_ff, sda_oe_ff, nxt_sda_oe;
  logic scl_s, sda_s, scl_q, sda_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic hi_hit, addr_hit, byte_done, hit_now, hold_now, lo_miss;
  logic ack_bit, ack_fall, ack_ok, to_tx, mack_fall, mack_rise, coll;
  logic ua_set, irq_set, ckp_clr;

  // pins pass two flops before anything looks at them
  i2cst_sync #(.WIDTH(2)) u_sync (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .d_i({scl_i, sda_i}),
    .q_o({scl_s, sda_s})
  );

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

  // address compare
  always_comb begin
    hi_hit = (sr_ff[7:3] == ADDR10_HI) && (sr_ff[2:1] == own_ff[2:1]);
    if (!ten_bit_i) begin
      addr_hit = sr_ff[7:1] == own_ff[7:1];
    end else if (lo_ff) begin
      addr_hit = sr_ff == own_ff;
    end else begin
      // a high read is only valid after a full write match
      addr_hit = hi_hit && (!sr_ff[0] || hi_ok_ff);
    end
  end

  assign byte_done = (state_ff == ST_RX) && scl_fall && (cnt_ff == CNT_BYTE);
  assign hit_now = byte_done && (!is_addr_ff || addr_hit);
  assign hold_now = is_addr_ff ? address_hold_enable_i : data_hold_enable_i;
  assign lo_miss = byte_done && is_addr_ff && ten_bit_i && lo_ff && !addr_hit;
  assign ack_bit = held_ff ? ack_value_select_i : nack_ff;
  assign ack_fall = (state_ff == ST_ACK) && scl_fall;
  assign ack_ok = ack_fall && !ack_bit;
  assign to_tx = ack_ok && is_addr_ff && rw_ff;
  assign mack_fall = (state_ff == ST_MACK) && scl_fall;
  assign mack_rise = (state_ff == ST_MACK) && scl_rise;
  // a released one read back as low means someone else drives
  assign coll = (state_ff == ST_TX) && scl_rise && !sda_oe_ff && !sda_s
    && slave_collision_detect_enable_i;

  assign ua_set = (ack_ok && is_addr_ff && ten_bit_i && !rw_ff) || lo_miss;
  assign irq_set = (hit_now && hold_now) || ack_ok || mack_fall || lo_miss;
  // address bytes in 10-bit mode stretch through the update flag instead
  assign ckp_clr = (hit_now && hold_now)
    || to_tx
    || (mack_fall && !ack_received_flag_ff)
    || (ack_ok && !to_tx && stretch_enable_i && !(is_addr_ff && ten_bit_i));

  // sequencer
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state_ff <= ST_IDLE;
      cnt_ff <= CNT_RST;
      sr_ff <= BYTE_RST;
      is_addr_ff <= 1'b0;
      lo_ff <= 1'b0;
      hi_ok_ff <= 1'b0;
      held_ff <= 1'b0;
      nack_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff <= ST_IDLE;
      hi_ok_ff <= 1'b0;
    end else if (start_det) begin
      state_ff <= ST_RX;
      cnt_ff <= CNT_RST;
      is_addr_ff <= 1'b1;
      lo_ff <= 1'b0;
    end else if (buf_wr_i) begin
      sr_ff <= buf_wdata_i;
    end else begin
      case (state_ff)
        ST_RX: begin
          if (scl_rise && cnt_ff != CNT_BYTE) begin
            sr_ff <= {sr_ff[6:0], sda_s};
            cnt_ff <= cnt_ff + 4'h1;
          end else if (byte_done) begin
            if (!hit_now) begin
              state_ff <= ST_IDLE;
            end else begin
              state_ff <= ST_ACK;
              held_ff <= hold_now;
              // a full buffer refuses a data byte
              nack_ff <= !is_addr_ff && bf_ff;
            end
          end
        end
        ST_ACK: begin
          if (ack_fall) begin
            cnt_ff <= CNT_RST;
            if (ack_bit) begin
              state_ff <= ST_IDLE;
            end else if (to_tx) begin
              state_ff <= ST_TX;
            end else if (is_addr_ff && ten_bit_i && !lo_ff) begin
              state_ff <= ST_RX;
              lo_ff <= 1'b1;
            end else begin
              state_ff <= ST_RX;
              hi_ok_ff <= hi_ok_ff | (is_addr_ff && ten_bit_i);
              is_addr_ff <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (coll) begin
            state_ff <= ST_IDLE;
          end else if (scl_fall) begin
            if (cnt_ff == CNT_TX_LAST) begin
              state_ff <= ST_MACK;
            end else begin
              sr_ff <= {sr_ff[6:0], 1'b0};
              cnt_ff <= cnt_ff + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (mack_fall) begin
            cnt_ff <= CNT_RST;
            state_ff <= ack_received_flag_ff ? ST_IDLE : ST_TX;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // sda drive: only moves while scl is low
  always_comb begin
    case (state_ff)
      ST_ACK: nxt_sda_oe = held_ff ? (ckp_ff && !ack_value_select_i) : !nack_ff;
      ST_TX: nxt_sda_oe = !sr_ff[7];
      default: nxt_sda_oe = 1'b0;
    endcase
  end

  // pin drivers
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      // grab scl only after it is seen low so the high time is never cut
      scl_oe_ff <= (!ckp_ff || ua_ff) && (!scl_s || scl_oe_ff);
      sda_oe_ff <= nxt_sda_oe;
    end
  end

  // clock release: a hardware clear beats a simultaneous software set
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ckp_ff <= CKP_RST;
    end else if (ckp_clr) begin
      ckp_ff <= 1'b0;
    end else if (clock_release_set_i) begin
      ckp_ff <= 1'b1;
    end
  end

  // event flags: set wins over clear
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      irq_ff <= 1'b0;
      bcl_ff <= 1'b0;
      ua_ff <= 1'b0;
      ack_time_flag_ff <= 1'b0;
    end else begin
      if (irq_set) begin
        irq_ff <= 1'b1;
      end else if (irq_clr_i) begin
        irq_ff <= 1'b0;
      end
      if (coll) begin
        bcl_ff <= 1'b1;
      end else if (bcl_clr_i) begin
        bcl_ff <= 1'b0;
      end
      if (ua_set) begin
        ua_ff <= 1'b1;
      end else if (own_addr_wr_i) begin
        ua_ff <= 1'b0;
      end
      if (hit_now && hold_now) begin
        ack_time_flag_ff <= 1'b1;
      end else if (ack_fall || start_det) begin
        ack_time_flag_ff <= 1'b0;
      end
    end
  end

  // data and status registers
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      buf_ff <= BYTE_RST;
      bf_ff <= 1'b0;
      rw_ff <= 1'b0;
      ack_received_flag_ff <= 1'b0;
      own_ff <= OWN_ADDR_RST;
    end else begin
      if (hit_now) begin
        buf_ff <= sr_ff;
        bf_ff <= 1'b1;
      end else if (buf_wr_i) begin
        buf_ff <= buf_wdata_i;
        bf_ff <= 1'b1;
      end else if (mack_rise || buf_rd_i) begin
        bf_ff <= 1'b0;
      end
      if (hit_now && is_addr_ff && !lo_ff) begin
        rw_ff <= sr_ff[0];
      end
      if (mack_rise) begin
        ack_received_flag_ff <= sda_s;
      end
      if (own_addr_wr_i) begin
        own_ff <= own_addr_wdata_i;
      end
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_oe_ff;
  assign sda_oe_o = sda_oe_ff;
  assign buffer_register_o = buf_ff;
  assign own_address_register_o = own_ff;
  assign read_write_flag_o = rw_ff;
  assign buffer_full_flag_o = bf_ff;
  assign update_address_flag_o = ua_ff;
  assign ack_received_flag_o = ack_received_flag_ff;
  assign ack_time_flag_o = ack_time_flag_ff;
  assign serial_irq_flag_o = irq_ff;
  assign bus_collision_flag_o = bcl_ff;
  assign clock_release_o = ckp_ff;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_tx_entry_stretch;
    (state_ff != ST_TX) ##1 (state_ff == ST_TX) |-> !ckp_ff;
  endproperty
  a_tx_entry_stretch: assert property (p_tx_entry_stretch) else $error("tx entered with release");

  property p_buf_loads_sr;
    buf_wr_i && !start_det && !stop_det |=> sr_ff == $past(buf_wdata_i) && buf_ff == sr_ff;
  endproperty
  a_buf_loads_sr: assert property (p_buf_loads_sr) else $error("buffer write missed shifter");

  property p_ack_sample;
    mack_rise && !stop_det && !start_det |=> ack_received_flag_ff == $past(sda_s);
  endproperty
  a_ack_sample: assert property (p_ack_sample) else $error("ack not captured");

  property p_nack_idle;
    mack_fall && ack_received_flag_ff && !stop_det && !start_det |=> state_ff == ST_IDLE && irq_ff
      ##1 !scl_oe_ff;
  endproperty
  a_nack_idle: assert property (p_nack_idle) else $error("nack did not end transfer");

  property p_irq_ninth;
    (ack_ok || mack_fall) |=> irq_ff [*2];
  endproperty
  a_irq_ninth: assert property (p_irq_ninth) else $error("irq not set on ninth fall");

  property p_collision;
    coll && !stop_det && !start_det |=> bcl_ff && state_ff == ST_IDLE;
  endproperty
  a_collision: assert property (p_collision) else $error("collision not flagged");

  property p_addr_hold;
    hit_now && is_addr_ff && address_hold_enable_i |=> !ckp_ff && irq_ff && ack_time_flag_ff;
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address hold missing");

  property p_hold_after_low;
    !scl_oe_ff ##1 scl_oe_ff |-> $past(!scl_s);
  endproperty
  a_hold_after_low: assert property (p_hold_after_low) else $error("scl grabbed while high");

  property p_ua_release;
    own_addr_wr_i && !ua_set && ckp_ff && !ckp_clr |=> !ua_ff ##1 !scl_oe_ff;
  endproperty
  a_ua_release: assert property (p_ua_release) else $error("update stretch not freed");

  property p_lo_miss;
    lo_miss && !stop_det && !start_det |=> ua_ff && irq_ff && $stable(ckp_ff)
      && bf_ff == $past(bf_ff);
  endproperty
  a_lo_miss: assert property (p_lo_miss) else $error("low mismatch flags wrong");
endmodule

// ==== rtl/i2cst_sync.sv ====
// two-flop synchroniser for bus pins
`timescale 1ns/1ps
module i2cst_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // asynchronous in, synchronised out
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // idle bus is high, so reset to ones to avoid a false start
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule

// ==== verification/i2cst_ctl_model.sv ====
// controller-side bus model: start, stop and bit clocking with stretch wait
`timescale 1ns/1ps
module i2cst_ctl_model (
  // bus wires
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o,
  // hang report
  output logic timeout_o
);
  logic jam = 1'b0;

  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    timeout_o = 1'b0;
  end

  // free scl, then wait out a target stretch under a bound
  task up();
    int n;
    n = 0;
    scl_oe_o = 1'b0;
    while (scl_i !== 1'b1 && n < 5000) begin
      #2;
      n++;
    end
    if (n == 5000) timeout_o = 1'b1;
    #10;
  endtask

  // data set mid-low, sampled mid-high; jam breaks the bus on purpose
  task clk(input logic d, output logic s);
    sda_oe_o = !d || jam;
    #14;
    up();
    s = sda_i;
    #10;
    scl_oe_o = 1'b1;
    #14;
  endtask

  task start();
    sda_oe_o = 1'b0;
    #14;
    up();
    #10;
    sda_oe_o = 1'b1;
    #20;
    scl_oe_o = 1'b1;
    #14;
  endtask

  // leaves both lines released, so scl stands high between frames
  task stop();
    sda_oe_o = 1'b1;
    #14;
    up();
    #10;
    sda_oe_o = 1'b0;
    #20;
  endtask

  task tx(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clk(b[i], s);
  endtask

  task rx(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clk(1'b1, b[i]);
    clk(nack, s);
  endtask
endmodule

// ==== verification/i2cst_slave_bench.sv ====
// self-checking bench: read, address hold, collision, 10-bit and stretch cases
`timescale 1ns/1ps
module i2cst_slave_bench;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic ten = 1'b0, address_hold_enable = 1'b0, data_hold_enable = 1'b0, stretch_enable = 1'b0, sbc = 1'b0, avs = 1'b0;
  logic bw = 1'b0, br = 1'b0, ow = 1'b0, rl = 1'b0, ic = 1'b0, bc = 1'b0;
  logic [7:0] wd = 8'h00;
  logic scl_o, scl_oe, sda_o, sda_oe, m_scl_oe, m_sda_oe, m_to;
  logic [7:0] bufr, d;
  logic rw, bf, ua, ackr, ackt, irq, bcl, clock_release, a;
  int error_cnt = 0;
  int tests_run = 0;
  // pull-ups: a released line reads high
  wire scl = !((scl_oe && !scl_o) || m_scl_oe);
  wire sda = !((sda_oe && !sda_o) || m_sda_oe);

  always #2 core_clk = !core_clk;

  i2cst_slave u_dut (
    .core_clk_i(core_clk), .nrst_i(nrst),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .ten_bit_i(ten), .address_hold_enable_i(address_hold_enable), .data_hold_enable_i(data_hold_enable),
    .stretch_enable_i(stretch_enable), .slave_collision_detect_enable_i(sbc),
    .ack_value_select_i(avs), .buf_wr_i(bw), .buf_wdata_i(wd), .buf_rd_i(br),
    .own_addr_wr_i(ow), .own_addr_wdata_i(wd), .clock_release_set_i(rl),
    .irq_clr_i(ic), .bcl_clr_i(bc), .buffer_register_o(bufr),
    .own_address_register_o(), .read_write_flag_o(rw), .buffer_full_flag_o(bf),
    .update_address_flag_o(ua), .ack_received_flag_o(ackr), .ack_time_flag_o(ackt),
    .serial_irq_flag_o(irq), .bus_collision_flag_o(bcl), .clock_release_o(clock_release)
  );

  i2cst_ctl_model u_mst (
    .scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe), .timeout_o(m_to)
  );

  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task results();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // a stuck scl wait is a hang
  always @(posedge m_to) begin
    error_cnt++;
    $display("unexpected scl_wait expected 0 seen 1");
    results();
  end

  task w(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // one-cycle software strobe: 0 buf wr, 1 release, 2 own wr, 3 irq clr, 4 bcl clr, 5 buf rd
  task sw(input int k, input logic [7:0] v);
    @(negedge core_clk);
    wd = v;
    case (k)
      0: bw = 1'b1;
      1: rl = 1'b1;
      2: ow = 1'b1;
      3: ic = 1'b1;
      4: bc = 1'b1;
      default: br = 1'b1;
    endcase
    @(negedge core_clk);
    {bw, rl, ow, ic, bc, br} = 6'h00;
  endtask

  task addr(input logic [7:0] b);
    u_mst.start();
    u_mst.tx(b);
    u_mst.clk(1'b1, a);
    w(4);
  endtask

  task t_read();
    sw(2, 8'ha0);
    addr(8'ha1);
    chk("addr_ack", a, 1'b0);
    chk("rw", rw, 1'b1);
    chk("buf", bufr, 8'ha1);
    chk("irq", irq, 1'b1);
    chk("ckp", clock_release, 1'b0);
    chk("scl_hold", scl_oe, 1'b1);
    for (int i = 0; i < 2; i++) begin
      sw(3, 8'h00);
      sw(0, i ? 8'h3c : 8'h96);
      sw(1, 8'h00);
      u_mst.rx(i[0], d);
      w(4);
      chk("data", d, i ? 8'h3c : 8'h96);
      chk("ack_received_flag", ackr, i[0]);
      chk("irq", irq, 1'b1);
      chk("ckp", clock_release, i[0]);
      chk("scl_hold", scl_oe, !i[0]);
    end
    u_mst.stop();
    $display("t_read end");
  endtask

  task t_hold(input logic v);
    address_hold_enable = 1'b1;
    avs = v;
    sw(3, 8'h00);
    u_mst.start();
    u_mst.tx(8'ha1);
    w(4);
    chk("ckp", clock_release, 1'b0);
    chk("irq", irq, 1'b1);
    chk("ack_time_flag", ackt, 1'b1);
    chk("scl_hold", scl_oe, 1'b1);
    sw(3, 8'h00);
    sw(1, 8'h00);
    u_mst.clk(1'b1, a);
    w(4);
    chk("held_ack", a, v);
    chk("ckp", clock_release, v);
    chk("irq", irq, !v);
    if (!v) begin
      sw(0, 8'h5a);
      sw(1, 8'h00);
      u_mst.rx(1'b1, d);
      chk("data", d, 8'h5a);
    end
    u_mst.stop();
    address_hold_enable = 1'b0;
    $display("t_hold end");
  endtask

  task t_coll();
    sbc = 1'b1;
    addr(8'ha1);
    sw(0, 8'hff);
    sw(1, 8'h00);
    u_mst.jam = 1'b1;
    u_mst.rx(1'b1, d);
    u_mst.jam = 1'b0;
    w(4);
    chk("bcl", bcl, 1'b1);
    chk("sda_drv", sda_oe, 1'b0);
    chk("scl_hold", scl_oe, 1'b0);
    u_mst.stop();
    sw(4, 8'h00);
    sbc = 1'b0;
    $display("t_coll end");
  endtask

  task t_ten();
    ten = 1'b1;
    sw(2, 8'hf2);
    addr(8'hf2);
    chk("hi_ack", a, 1'b0);
    chk("ua", ua, 1'b1);
    chk("ckp", clock_release, 1'b1);
    chk("scl_hold", scl_oe, 1'b1);
    sw(5, 8'h00);
    sw(2, 8'h55);
    w(2);
    chk("ua", ua, 1'b0);
    chk("scl_hold", scl_oe, 1'b0);
    u_mst.tx(8'h56);
    w(4);
    // a low-byte miss stretches before the ninth clock until own address is rewritten
    chk("ua", ua, 1'b1);
    chk("bf", bf, 1'b0);
    chk("ckp", clock_release, 1'b1);
    chk("scl_hold", scl_oe, 1'b1);
    sw(2, 8'hf2);
    u_mst.clk(1'b1, a);
    chk("lo_nack", a, 1'b1);
    u_mst.stop();
    addr(8'hf2);
    sw(2, 8'h55);
    u_mst.tx(8'h55);
    u_mst.clk(1'b1, a);
    w(4);
    sw(2, 8'hf2);
    sw(5, 8'h00);
    stretch_enable = 1'b1;
    u_mst.tx(8'h12);
    u_mst.clk(1'b1, a);
    w(4);
    chk("buf", bufr, 8'h12);
    chk("ckp", clock_release, 1'b0);
    chk("scl_hold", scl_oe, 1'b1);
    stretch_enable = 1'b0;
    data_hold_enable = 1'b1;
    sw(5, 8'h00);
    sw(1, 8'h00);
    u_mst.tx(8'h34);
    w(4);
    chk("ckp", clock_release, 1'b0);
    avs = 1'b1;
    sw(1, 8'h00);
    u_mst.clk(1'b1, a);
    chk("data_nack", a, 1'b1);
    u_mst.stop();
    {ten, data_hold_enable, avs} = 3'h0;
    $display("t_ten end");
  endtask

  initial begin
    repeat (20) @(negedge core_clk);
    chk("ckp", clock_release, 1'b1);
    chk("scl_hold", scl_oe, 1'b0);
    chk("sda_drv", sda_oe, 1'b0);
    chk("ua", ua, 1'b0);
    chk("bf", bf, 1'b0);
    nrst = 1'b1;
    w(3);
    t_read();
    t_hold(1'b0);
    t_hold(1'b1);
    t_coll();
    t_ten();
    results();
  end
endmodule
